// [logic/sep_cmd_proxy.sv]
`timescale 1ns/1ps
// How it works
// - command bit 0: 0 write, 1 read
// - bit 1 picks host-given bus address
// - bit 3 flags unexpected master NACK
// - bit 4 flags sixteen straight arbitration losses
// - bit 5 flags misplaced START or STOP
// - error bits clear on read, mirror status
module sep_cmd_proxy
  import sep_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // configuration
  input  wire logic [6:0]        ownSlaveAddr,
  input  wire logic [7:0]        defaultEepromBusAddr,
  // slave link pins
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sdaOut,
  output logic                   sdaOeN,
  // master bus engine
  output sep_pkg::sep_mreq_t     masterReq,
  input  wire sep_pkg::sep_mrsp_t masterRsp,
  // status mirror: misplaced, arb loss, nack
  output logic [2:0]             masterBusStatusReg,
  output logic                   busy
);
  import sep_pkg::*;

  // whole block state
  typedef struct packed {
    sep_state_t state;
    logic [2:0] bitCnt;
    logic [7:0] shReg;
    logic       anyRise;    // a rising clock seen in this byte
    logic       isAddr;     // receiving the slave address
    logic       readMode;   // host reads from us
    logic       ackIt;      // drive ack in the ack slot
    logic [2:0] rxIdx;      // next request byte position
    logic [2:0] txIdx;      // next read-back byte position
    logic [7:0] cmd;
    logic [7:0] busAddrByte;
    logic [7:0] lowByte;
    logic [7:0] highByte;
    logic [7:0] dataByte;
    logic [2:0] errFlags;   // {misplaced, arb loss, nack}
    logic [4:0] arbRun;     // consecutive lost arbitrations
    logic       sdaOeN;
    sep_mreq_t  mreq;
    logic       busy;
  } sep_proxy_t;

  sep_proxy_t st_ff;   // registered state
  sep_proxy_t nxt_st;  // next state
  sep_link_t  linkEv;  // decoded link events

  // link sampling
  sep_link_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .linkEv  (linkEv)
  );

  // read-back byte at a position
  function automatic logic [7:0] txByte(input sep_proxy_t s,
                                        input logic [2:0] idx);
    case (idx)
      3'h0:    txByte = RD_BACK_COUNT;
      3'h1:    txByte = {s.cmd[7:6], s.errFlags, s.cmd[2:0]};
      3'h2:    txByte = s.busAddrByte;
      3'h3:    txByte = s.lowByte;
      3'h4:    txByte = s.highByte;
      3'h5:    txByte = s.dataByte;
      default: txByte = IDLE_BYTE;
    endcase
  endfunction

  // next-state logic
  always_comb
  begin
    nxt_st = st_ff;
    // master engine answer: count lost attempts, close the access, latch read data
    if (masterRsp.arbLost)
    begin
      // saturating run of lost attempts
      if (st_ff.arbRun != ARB_LOSS_LIMIT)
        nxt_st.arbRun = st_ff.arbRun + 5'h01;
    end
    else if (masterRsp.arbWon)
      nxt_st.arbRun = 5'h00;
    if (masterRsp.done && st_ff.busy)
    begin
      nxt_st.busy     = 1'b0;
      nxt_st.mreq.req = 1'b0;
      if (st_ff.mreq.opRead)
        nxt_st.dataByte = masterRsp.rdData;
    end

    case (st_ff.state)
      // wait for a start
      ST_IDLE:
      begin
        nxt_st.sdaOeN = 1'b1;
      end
      // shift in a byte on rising clock
      ST_RXBIT:
      begin
        if (linkEv.sclRise)
        begin
          nxt_st.shReg   = {st_ff.shReg[6:0], linkEv.sda};
          nxt_st.bitCnt  = st_ff.bitCnt + 3'h1;
          nxt_st.anyRise = 1'b1;
        end
        // a fall before any bit is the tail of a start, not a byte end
        else if (linkEv.sclFall && st_ff.bitCnt == 3'h0 &&
                 st_ff.anyRise)
        begin
          // eight bits in: decide the ack
          nxt_st.state   = ST_ACK;
          nxt_st.anyRise = 1'b0;
          if (st_ff.isAddr)
          begin
            nxt_st.ackIt    = (st_ff.shReg[7:1] == ownSlaveAddr);
            nxt_st.readMode = st_ff.shReg[0];
            nxt_st.txIdx    = 3'h0;
            if (!st_ff.shReg[0])
              nxt_st.rxIdx = POS_SLAVE_COMMAND_CODE;
          end
          else
          begin
            // busy with an access: refuse the code
            if (st_ff.rxIdx == POS_SLAVE_COMMAND_CODE)
              nxt_st.ackIt = !st_ff.busy;
            else
              nxt_st.ackIt = 1'b1;
            // store by position, fixed order from host
            case (st_ff.rxIdx)
              POS_CMD:   nxt_st.cmd         = st_ff.shReg;
              POS_BADDR: nxt_st.busAddrByte = st_ff.shReg;
              POS_LOW:   nxt_st.lowByte     = st_ff.shReg;
              POS_HIGH:  nxt_st.highByte    = st_ff.shReg;
              POS_DATA:  nxt_st.dataByte    = st_ff.shReg;
              default:   nxt_st.cmd         = st_ff.cmd;
            endcase
            if (st_ff.rxIdx != WR_REQ_BYTES)
              nxt_st.rxIdx = st_ff.rxIdx + 3'h1;
          end
          nxt_st.sdaOeN = !nxt_st.ackIt;
        end
      end
      // ack slot ends on the falling clock
      ST_ACK:
      begin
        if (linkEv.sclFall)
        begin
          nxt_st.isAddr = 1'b0;
          nxt_st.bitCnt = 3'h0;
          if (!st_ff.ackIt)
          begin
            // refused: ignore the rest until the next start
            nxt_st.state  = ST_IDLE;
            nxt_st.sdaOeN = 1'b1;
          end
          else if (st_ff.readMode)
          begin
            // load the next read-back byte, msb first
            nxt_st.shReg  = txByte(st_ff, st_ff.txIdx);
            nxt_st.sdaOeN = txByte(st_ff, st_ff.txIdx) >> 7 != 8'h00;
            nxt_st.state  = ST_TXBIT;
            if (st_ff.txIdx == 3'h1)
              nxt_st.errFlags = ERR_RST;
            if (st_ff.txIdx != POS_DATA)
              nxt_st.txIdx = st_ff.txIdx + 3'h1;
          end
          else
          begin
            nxt_st.state  = ST_RXBIT;
            nxt_st.sdaOeN = 1'b1;
          end
          nxt_st.ackIt = 1'b0;
        end
      end
      // drive the remaining bits on falling clock
      ST_TXBIT:
      begin
        if (linkEv.sclFall)
        begin
          if (st_ff.bitCnt == 3'h7)
          begin
            nxt_st.sdaOeN = 1'b1;
            nxt_st.state  = ST_TXACK;
          end
          else
          begin
            nxt_st.shReg  = {st_ff.shReg[6:0], 1'b0};
            nxt_st.sdaOeN = st_ff.shReg[6];
            nxt_st.bitCnt = st_ff.bitCnt + 3'h1;
          end
        end
      end
      // host acks to go on, nacks to finish
      ST_TXACK:
      begin
        if (linkEv.sclRise)
        begin
          nxt_st.state = linkEv.sda ? ST_IDLE : ST_ACK;
          // host ack keeps the read-back going in the ack slot
          nxt_st.ackIt = !linkEv.sda;
        end
      end
      default:
      begin
        nxt_st.state  = ST_IDLE;
        nxt_st.sdaOeN = 1'b1;
      end
    endcase

    // master errors set the flags; set wins over the read clear
    if (masterRsp.done && st_ff.busy && masterRsp.nackErr)
      nxt_st.errFlags[0] = 1'b1;
    if (masterRsp.arbLost && st_ff.arbRun == ARB_LOSS_LIMIT - 5'h01)
      nxt_st.errFlags[1] = 1'b1;
    if (masterRsp.misplaced)
      nxt_st.errFlags[2] = 1'b1;

    // start or repeated start restarts the byte engine
    if (linkEv.start)
    begin
      nxt_st.state  = ST_RXBIT;
      nxt_st.isAddr = 1'b1;
      nxt_st.anyRise = 1'b0;
      nxt_st.bitCnt = 3'h0;
      nxt_st.ackIt  = 1'b0;
      nxt_st.sdaOeN = 1'b1;
    end
    else if (linkEv.stop)
    begin
      nxt_st.state  = ST_IDLE;
      nxt_st.sdaOeN = 1'b1;
      // a complete request launches the master access
      if (!st_ff.busy && !st_ff.readMode &&
          (st_ff.cmd[CMD_OP_BIT] ? st_ff.rxIdx >= RD_REQ_BYTES
                                 : st_ff.rxIdx >= WR_REQ_BYTES))
      begin
        nxt_st.busy          = 1'b1;
        nxt_st.mreq.req      = 1'b1;
        nxt_st.mreq.opRead   = st_ff.cmd[CMD_OP_BIT];
        nxt_st.mreq.busAddr  = st_ff.cmd[CMD_USE_ADDR_BIT] ?
                               st_ff.busAddrByte :
                               defaultEepromBusAddr;
        nxt_st.mreq.byteAddr = {st_ff.highByte, st_ff.lowByte};
        nxt_st.mreq.wrData   = st_ff.dataByte;
        nxt_st.arbRun        = 5'h00;
      end
      nxt_st.rxIdx = POS_SLAVE_COMMAND_CODE;
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff        <= '0;
      st_ff.state  <= ST_IDLE;
      st_ff.sdaOeN <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from flops; pin only ever pulls low
  assign sdaOut             = 1'b0;
  assign sdaOeN             = st_ff.sdaOeN;
  assign masterReq          = st_ff.mreq;
  assign masterBusStatusReg = st_ff.errFlags;
  assign busy               = st_ff.busy;

endmodule

// [logic/sep_link_sync.sv]
`timescale 1ns/1ps
module sep_link_sync
  import sep_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // raw link pins
  input  wire logic          sclIn,
  input  wire logic          sdaIn,
  // decoded events
  output sep_pkg::sep_link_t linkEv
);

  // three-stage synchroniser plus one history stage
  typedef struct packed {
    logic [1:0] sclMeta;
    logic [1:0] sdaMeta;
    logic       sclSync;
    logic       sdaSync;
    logic       sclOld;
    logic       sdaOld;
  } sep_sync_t;

  sep_sync_t syn_ff;   // registered state
  sep_sync_t nxt_syn;  // next state

  // first stage feeds only the second stage
  always_comb
  begin
    nxt_syn         = syn_ff;
    nxt_syn.sclMeta = {syn_ff.sclMeta[0], sclIn};
    nxt_syn.sdaMeta = {syn_ff.sdaMeta[0], sdaIn};
    nxt_syn.sclSync = syn_ff.sclMeta[1];
    nxt_syn.sdaSync = syn_ff.sdaMeta[1];
    nxt_syn.sclOld  = syn_ff.sclSync;
    nxt_syn.sdaOld  = syn_ff.sdaSync;
  end

  // idle bus is high, so reset to high
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      syn_ff <= '1;
    else
      syn_ff <= nxt_syn;
  end

  // edges only on synchronised stages
  assign linkEv.sclRise = syn_ff.sclSync & ~syn_ff.sclOld;
  assign linkEv.sclFall = ~syn_ff.sclSync & syn_ff.sclOld;
  assign linkEv.start   = syn_ff.sclSync & syn_ff.sclOld &
                          ~syn_ff.sdaSync & syn_ff.sdaOld;
  assign linkEv.stop    = syn_ff.sclSync & syn_ff.sclOld &
                          syn_ff.sdaSync & ~syn_ff.sdaOld;
  assign linkEv.sda     = syn_ff.sdaSync;

endmodule

// [logic/sep_pkg.sv]
package sep_pkg;

  // command byte field positions
  localparam int CMD_OP_BIT       = 0;
  localparam int CMD_USE_ADDR_BIT = 1;
  localparam int CMD_NACK_BIT     = 3;
  localparam int CMD_ARB_BIT      = 4;
  localparam int CMD_MISPL_BIT    = 5;

  // request byte positions after the slave address
  localparam logic [2:0] POS_SLAVE_COMMAND_CODE = 3'h0;
  localparam logic [2:0] POS_COUNT = 3'h1;
  localparam logic [2:0] POS_CMD   = 3'h2;
  localparam logic [2:0] POS_BADDR = 3'h3;
  localparam logic [2:0] POS_LOW   = 3'h4;
  localparam logic [2:0] POS_HIGH  = 3'h5;
  localparam logic [2:0] POS_DATA  = 3'h6;

  // bytes needed before a stop launches a request
  localparam logic [2:0] RD_REQ_BYTES = 3'h6;
  localparam logic [2:0] WR_REQ_BYTES = 3'h7;

  // byte count returned on the read-back
  localparam logic [7:0] RD_BACK_COUNT = 8'h05;
  // filler after the last read-back byte
  localparam logic [7:0] IDLE_BYTE     = 8'hFF;

  // consecutive lost arbitrations that make an error
  localparam logic [4:0] ARB_LOSS_LIMIT = 5'h10;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] ERR_RST  = 3'h0;

  // slave byte engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b0_0001,
    ST_RXBIT = 5'b0_0010,
    ST_ACK   = 5'b0_0100,
    ST_TXBIT = 5'b0_1000,
    ST_TXACK = 5'b1_0000
  } sep_state_t;

  // request toward the master bus engine
  typedef struct packed {
    logic        req;
    logic        opRead;
    logic [7:0]  busAddr;
    logic [15:0] byteAddr;
    logic [7:0]  wrData;
  } sep_mreq_t;

  // answer from the master bus engine
  typedef struct packed {
    logic       done;
    logic       nackErr;
    logic       arbLost;
    logic       arbWon;
    logic       misplaced;
    logic [7:0] rdData;
  } sep_mrsp_t;

  // decoded link events
  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
    logic sda;
  } sep_link_t;

endpackage

// [tb/sep_cmd_proxy_chk.sv]
`timescale 1ns/1ps
module sep_cmd_proxy_chk
  import sep_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               reset_n,
  // watched outputs
  input wire logic               busy,
  input wire logic [2:0]         masterBusStatusReg,
  input wire sep_pkg::sep_mreq_t masterReq,
  // engine answers
  input wire sep_pkg::sep_mrsp_t masterRsp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // lost attempts in a row; idle or a win restarts the run
  logic [4:0] arbRun_ff;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      arbRun_ff <= 5'h0;
    else if (masterRsp.arbWon || !masterReq.req)
      arbRun_ff <= 5'h0;
    else if (masterRsp.arbLost && arbRun_ff != 5'h1F)
      arbRun_ff <= arbRun_ff + 5'h1;
  end

  // access finished by the engine
  sequence s_done;
    busy && masterRsp.done;
  endsequence
  // the sixteenth straight loss
  sequence s_lost16;
    masterRsp.arbLost && arbRun_ff == 5'h0F;
  endsequence

  a_busy_req_tie: assert property (busy == masterReq.req)
    else $error("busy and request differ");
  a_done_ends: assert property (s_done |=> !busy && !masterReq.req)
    else $error("access still open after done");
  a_req_held: assert property (
    masterReq.req && !masterRsp.done |=> $stable(masterReq))
    else $error("request changed while open");
  a_nack_sets: assert property (
    s_done ##0 masterRsp.nackErr |=> masterBusStatusReg[0])
    else $error("nack flag missed");
  a_nack_cause: assert property (
    $rose(masterBusStatusReg[0])
    |-> $past(masterRsp.done) && $past(masterRsp.nackErr))
    else $error("nack flag without cause");
  a_arb_sets: assert property (s_lost16 |=> masterBusStatusReg[1])
    else $error("arbitration flag missed");
  a_arb_cause: assert property (
    $rose(masterBusStatusReg[1])
    |-> $past(masterRsp.arbLost) && $past(arbRun_ff) == 5'h0F)
    else $error("arbitration flag too early");
  a_mispl_sets: assert property (
    masterRsp.misplaced |=> masterBusStatusReg[2])
    else $error("misplaced flag missed");
  a_mispl_cause: assert property (
    $rose(masterBusStatusReg[2]) |-> $past(masterRsp.misplaced))
    else $error("misplaced flag without cause");
endmodule

bind sep_cmd_proxy sep_cmd_proxy_chk u_chk (
  .clk               (clk),
  .reset_n           (reset_n),
  .busy              (busy),
  .masterBusStatusReg(masterBusStatusReg),
  .masterReq         (masterReq),
  .masterRsp         (masterRsp)
);

// [tb/sep_host.sv]
`timescale 1ns/1ps
// link host; scl stands high between frames
module sep_host
(
  // wired sda level
  input  wire logic sda,
  // host pins, sdaH 1 means released to pull-up
  output logic      scl,
  output logic      sdaH
);
  initial
  begin
    scl  = 1'b1;
    sdaH = 1'b1;
  end
  // one bit, 160 ns; data moves only while scl is low
  task automatic bitx(input logic b, output logic r);
    #20 sdaH = b;
    #60 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  // start or repeated start
  task automatic start();
    #20 sdaH = 1'b1;
    #60 scl = 1'b1;
    #80 sdaH = 1'b0;
    #80 scl = 1'b0;
  endtask
  // stop closes the request frame
  task automatic stop();
    #20 sdaH = 1'b0;
    #60 scl = 1'b1;
    #80 sdaH = 1'b1;
    #80;
  endtask
  // msb first, then release for the ack
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // released sda while the device sends
  task automatic rdByte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(!ack, r);
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import sep_pkg::*;
  // clock, reset, pins
  logic       clk, reset_n, scl, sdaH, sda, sdaOut, sdaOeN, busy;
  logic [2:0] stat;
  sep_mreq_t  mReq;
  sep_mrsp_t  mRsp;
  int         num_errors, n_checks;

  // open drain: either party can pull low
  assign sda = sdaH & (sdaOeN | sdaOut);

  sep_host u_host (.sda(sda), .scl(scl), .sdaH(sdaH));
  sep_cmd_proxy u_dut (
    .clk(clk), .reset_n(reset_n), .ownSlaveAddr(7'h5A),
    .defaultEepromBusAddr(8'hA0), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .masterReq(mReq),
    .masterRsp(mRsp), .masterBusStatusReg(stat), .busy(busy));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [23:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one request frame, every byte acked
  task automatic send(input logic [7:0] q[$]);
    logic a;
    u_host.start();
    foreach (q[i])
    begin
      u_host.wrByte(q[i], a);
      chk("ack", a, 1'b1);
    end
    u_host.stop();
  endtask

  // command code alone, then stop
  task automatic probe(input logic e);
    logic a;
    u_host.start();
    u_host.wrByte(8'hB4, a);
    u_host.wrByte(8'h10, a);
    chk("slave_command_code ack", a, e);
    u_host.stop();
  endtask

  // read-back through a repeated start
  task automatic fetch(input logic [7:0] q[$]);
    logic       a;
    logic [7:0] d;
    u_host.start();
    u_host.wrByte(8'hB4, a);
    u_host.wrByte(8'h10, a);
    chk("fetch slave_command_code", a, 1'b1);
    u_host.start();
    u_host.wrByte(8'hB5, a);
    foreach (q[i])
    begin
      u_host.rdByte(i < q.size() - 1, d);
      chk("rd", d, q[i]);
    end
    u_host.stop();
  endtask

  // master engine stand-in: losses, misplaced, then done
  task automatic eng(input logic nk, input int nArb,
                     input logic ms, input logic [7:0] d);
    // a won attempt breaks the run, so these losses must not count
    repeat (8)
    begin
      @(posedge clk) #1 mRsp.arbLost = 1'b1;
      @(posedge clk) #1 mRsp.arbLost = 1'b0;
    end
    mRsp.arbWon = 1'b1;
    @(posedge clk) #1 mRsp.arbWon = 1'b0;
    repeat (nArb)
    begin
      @(posedge clk) #1 mRsp.arbLost = 1'b1;
      @(posedge clk) #1 mRsp.arbLost = 1'b0;
    end
    @(posedge clk) #1 mRsp.misplaced = ms;
    @(posedge clk) #1 mRsp.misplaced = 1'b0;
    mRsp.done = 1'b1;
    mRsp.nackErr = nk;
    mRsp.rdData = d;
    @(posedge clk) #1 mRsp.done = 1'b0;
    mRsp.nackErr = 1'b0;
    @(posedge clk) #1;
    chk("closed", {busy, mReq.req}, 2'b00);
  endtask

  initial
  begin
    num_errors = 0;
    n_checks = 0;
    mRsp = '0;
    reset_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    #1000;
    // write, default bus address, reserved bits zero
    send('{8'hB4, 8'h10, 8'h05, 8'h00, 8'hA6, 8'h34, 8'h12,
           8'hC3});
    chk("launch", {busy, mReq.req}, 2'b11);
    chk("op", mReq.opRead, 1'b0);
    chk("baddr", mReq.busAddr, 8'hA0);
    chk("fields", {mReq.byteAddr, mReq.wrData}, 24'h12_34c3);
    probe(1'b0);
    eng(1'b1, 15, 1'b0, 8'h00);
    chk("stat", stat, 3'h1);
    // read, host-given bus address
    send('{8'hB4, 8'h10, 8'h04, 8'h03, 8'hA6, 8'h78,
           8'h56});
    chk("op", mReq.opRead, 1'b1);
    chk("baddr", mReq.busAddr, 8'hA6);
    probe(1'b0);
    eng(1'b0, 16, 1'b1, 8'h5A);
    chk("stat", stat, 3'h7);
    fetch('{8'h05, 8'h3B, 8'hA6, 8'h78, 8'h56, 8'h5A});
    chk("stat", stat, 3'h0);
    give_verdict();
  end

  // run needs about 45 us of link time
  initial
  begin
    #500_000;
    num_errors++;
    give_verdict();
  end
endmodule
